// ---- common/vmc_pkg.sv ----
// package for the volume, mix and mute block
// assumes a single 100 MHz clock domain
package vmc_pkg;
    // register indices on the simple register port
    localparam logic [2:0] REG_VOLMIX = 3'h2;
    localparam logic [2:0] REG_CHA    = 3'h3;
    localparam logic [2:0] REG_CHB    = 3'h4;
    localparam logic [2:0] REG_MODE2  = 3'h5;
    // reset values
    localparam logic [7:0] RST_VOLMIX = 8'h49;
    localparam logic [7:0] RST_CH     = 8'h00;
    localparam logic [7:0] RST_MODE2  = 8'h10;
    // volume and mix register fields
    localparam int VM_LINK  = 7;
    localparam int VM_SOFT  = 6;
    localparam int VM_ZC    = 5;
    localparam int VM_MIX_H = 4;
    // channel register fields
    localparam int CH_MUTE  = 7;
    // second mode register fields
    localparam int M2_INV_A  = 7;
    localparam int M2_INV_B  = 6;
    localparam int M2_HOST   = 5;
    localparam int M2_LOWPWR = 4;
    localparam int M2_FLINK  = 3;
    localparam int M2_FREEZE = 2;
    localparam int M2_MDIV   = 1;
    // level arithmetic, eighth-dB units
    localparam logic [6:0]  MAX_ATTEN   = 7'h77;
    localparam logic [10:0] LVL_SILENT  = 11'h3C0;
    localparam logic [9:0]  ZC_TIMEOUT  = 10'h200;
    localparam int          SAMPLE_W    = 24;
    localparam int          FIFO_DEPTH  = 4;
    // ramp and crossing modes
    typedef enum logic [1:0] {
        VMC_IMMED = 2'b00,
        VMC_ZERO  = 2'b01,
        VMC_SOFT  = 2'b10,
        VMC_BOTH  = 2'b11
    } vmc_mode_t;
endpackage : vmc_pkg

// ---- hw/vmc_fifo.sv ----
// small synchronous fifo with valid and ready on both sides
// assumes one clock, a clock enable and async active-low reset
module vmc_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             ce_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } vmc_fifo_st_t;
    vmc_fifo_st_t st, next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    // handshakes
    assign in_ready_out  = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid_out = (st.cnt != '0);
    assign out_data_out  = mem[st.rp];
    assign push = ce_in && in_valid_in && in_ready_out;
    assign pop  = ce_in && out_ready_in && out_valid_out;

    // pointer and count update
    always_comb begin
        next_st = st;
        if (push) next_st.wp = st.wp + 1'b1;
        if (pop) next_st.rp = st.rp + 1'b1;
        next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) st <= '0;
        else if (ce_in) st <= next_st;
    end

    // storage
    always_ff @(posedge clk_in) begin
        if (push) mem[st.wp] <= in_data_in;
    end
endmodule : vmc_fifo

// ---- hw/vmc_level.sv ----
// one channel level tracker: soft ramp, zero cross, timeout
// assumes frame_in pulses once per left/right clock period
module vmc_level
    import vmc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    input  wire logic        frame_in,
    input  wire logic        zero_in,
    input  wire vmc_pkg::vmc_mode_t mode_in,
    input  wire logic [10:0] target_in,
    output logic [10:0]      level_out,
    output logic             settled_out
);
    typedef struct packed {
        logic [10:0] lvl;
        logic [9:0]  wait_cnt;
    } vmc_lvl_st_t;
    vmc_lvl_st_t st, next_st;
    logic step_ok, moving;
    logic [10:0] one_step;

    assign level_out   = st.lvl;
    assign settled_out = (st.lvl == target_in);
    assign moving      = !settled_out;

    // an eighth-dB step toward the target
    always_comb begin
        if (target_in > st.lvl) one_step = st.lvl + 11'h001;
        else one_step = st.lvl - 11'h001;
    end

    // crossing or timeout gate, per channel
    assign step_ok = zero_in || (st.wait_cnt >= ZC_TIMEOUT - 10'h001); // RQ2 RQ3

    always_comb begin
        next_st = st;
        if (!moving) begin
            next_st.wait_cnt = '0;
        end else begin
            case (mode_in)
                VMC_IMMED: begin
                    next_st.lvl = target_in;
                end
                VMC_ZERO: begin
                    if (frame_in) begin
                        if (step_ok) begin
                            next_st.lvl = target_in; // RQ2
                            next_st.wait_cnt = '0;
                        end else begin
                            next_st.wait_cnt = st.wait_cnt + 10'h001;
                        end
                    end
                end
                VMC_SOFT: begin
                    if (frame_in) next_st.lvl = one_step; // RQ1 RQ23
                end
                VMC_BOTH: begin
                    if (frame_in) begin
                        if (step_ok) begin
                            next_st.lvl = one_step; // RQ4
                            next_st.wait_cnt = '0;
                        end else begin
                            next_st.wait_cnt = st.wait_cnt + 10'h001;
                        end
                    end
                end
                default: next_st.lvl = target_in;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) st <= '0;
        else if (ce_in) st <= next_st;
    end

    AST_SOFT_STEP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && frame_in && mode_in == VMC_SOFT && moving) |=>
        (st.lvl == $past(one_step)))
        else $error("soft ramp did not move one step"); // RQ1
    AST_ZC_TIMEOUT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        st.wait_cnt <= ZC_TIMEOUT)
        else $error("zero cross wait exceeded limit"); // RQ2
endmodule : vmc_level

// ---- hw/vmc_top.sv ----
// volume, mix, mute and mode register section of a stereo converter
// assumes a register write port from the serial control decoder and
// samples arriving as left/right pairs paced by the frame clock
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [RQ1] soft ramp moves eighth-dB, one dB per eight frames
// [RQ2] zero cross applies change, timeout 512 samples
// [RQ3] crossing tracked separately per channel
// [RQ4] both modes: eighth-dB step per crossing
// [RQ5] mode select decode, reset soft ramp
// [RQ6] mix decode, reset code 01001
// [RQ7] top mix bit: weighted averages, exceptions
// [RQ8] mute follows ramp and crossing rules
// [RQ9] silence flag active while mute bit set
// [RQ10] linked flags are AND of channels
// [RQ11] attenuation code n gives minus n dB
// [RQ12] code above 119 acts as mute
// [RQ13] invert bits negate channel samples
// [RQ14] host port enable resets to zero
// [RQ15] host writes 11h early after reset
// [RQ16] low power holds output, keeps registers; outputs are forced to zero and the fifo stalls
// [RQ17] freeze holds effects, releases all together
// [RQ18] master clock divide by two option
// [RQ19] reset restores all registers, blocks port
// [RQ20] stand-alone reset forces low power
// [RQ21] host holds reset until clocks stable
// [RQ22] volume link uses channel A setting
// [RQ23] one step per frame per channel
////////////////////////////////////////////////////////////////////////////////
module vmc_top
    import vmc_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                ce_in,
    input  wire logic                mclk_in,
    input  wire logic                frame_clock_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    input  wire logic [2:0]          reg_addr_in,
    input  wire logic [7:0]          reg_wdata_in,
    output logic [7:0]               reg_rdata_out,
    input  wire logic                smp_valid_in,
    output logic                     smp_ready_out,
    input  wire logic [SAMPLE_W-1:0] smp_left_in,
    input  wire logic [SAMPLE_W-1:0] smp_right_in,
    output logic                     out_valid_out,
    output logic [SAMPLE_W-1:0]      out_a_out,
    output logic [SAMPLE_W-1:0]      out_b_out,
    output logic                     chan_a_silence_flag_out,
    output logic                     chan_b_silence_flag_out,
    output logic                     low_power_out,
    output logic                     host_port_on_out,
    output logic                     core_clk_en_out
);
    import vmc_pkg::*;

    typedef struct packed {
        logic [7:0]          volmix;
        logic [7:0]          cha;
        logic [7:0]          chb;
        logic [7:0]          mode2;
        logic [7:0]          act_volmix;
        logic [7:0]          act_cha;
        logic [7:0]          act_chb;
        logic [1:0]          act_inv;
        logic                frame_d;
        logic                mdiv_ph;
        logic [SAMPLE_W-1:0] prev_a;
        logic [SAMPLE_W-1:0] prev_b;
        logic [7:0]          rdata;
        logic                ovalid;
        logic [SAMPLE_W-1:0] oa;
        logic [SAMPLE_W-1:0] ob;
        logic                flag_a;
        logic                flag_b;
        logic                lowpwr;
        logic                host;
        logic                cken;
    } vmc_top_st_t;
    vmc_top_st_t st, next_st;

    logic                     fifo_valid, fifo_pop;
    logic [2*SAMPLE_W-1:0]    fifo_data;
    logic                     frame_pulse;
    logic [10:0]              tgt [2];
    logic [10:0]              lvl [2];
    logic                     zc  [2];
    logic [SAMPLE_W-1:0]      mixed [2];
    logic [SAMPLE_W-1:0]      shaped [2];
    vmc_mode_t                mode;

    ////////////////////////////////////////////////////////////////////////////
    // sample fifo between the serial receiver and the mixer
    vmc_fifo #(
        .WIDTH (2*SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .ce_in         (ce_in),
        .in_valid_in   (smp_valid_in),
        .in_ready_out  (smp_ready_out),
        .in_data_in    ({smp_left_in, smp_right_in}),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_data)
    );

    // drain one pair per frame edge, stalls while powered down
    assign frame_pulse = frame_clock_in && !st.frame_d;
    assign fifo_pop    = frame_pulse && !st.lowpwr; // RQ16
    assign mode        = vmc_mode_t'(st.act_volmix[VM_SOFT:VM_ZC]); // RQ5

    ////////////////////////////////////////////////////////////////////////////
    // mixing on the active copy of the mix code
    function automatic logic [SAMPLE_W-1:0] avg(input logic [SAMPLE_W-1:0] x,
                                                input logic [SAMPLE_W-1:0] y);
        logic [SAMPLE_W:0] s;
        s = {x[SAMPLE_W-1], x} + {y[SAMPLE_W-1], y};
        return s[SAMPLE_W:1];
    endfunction : avg

    function automatic logic [SAMPLE_W-1:0] pick(input logic [1:0] sel,
                                                 input logic [SAMPLE_W-1:0] l,
                                                 input logic [SAMPLE_W-1:0] r,
                                                 input logic [SAMPLE_W-1:0] av);
        logic [SAMPLE_W-1:0] v;
        v = '0;
        case (sel)
            2'b00: v = '0;
            2'b01: v = r;
            2'b10: v = l;
            2'b11: v = av;
            default: v = '0;
        endcase
        return v;
    endfunction : pick

    // channel volumes apply to l and r before the weighted sums
    logic [SAMPLE_W-1:0] in_l, in_r, scl_l_a, scl_r_a, scl_l_b, scl_r_b;
    assign in_l = fifo_data[2*SAMPLE_W-1:SAMPLE_W];
    assign in_r = fifo_data[SAMPLE_W-1:0];

    always_comb begin
        if (!st.act_volmix[VM_MIX_H]) begin
            // plain mix: channel volume applies after the mix
            mixed[0] = pick(st.act_volmix[3:2], in_l, in_r, avg(in_l, in_r)); // RQ6
            mixed[1] = pick(st.act_volmix[1:0], in_l, in_r, avg(in_l, in_r)); // RQ6
        end else begin
            // weighted mix uses per-channel levels inside the sum
            mixed[0] = pick(st.act_volmix[3:2], scl_l_a, scl_r_a,
                (st.act_volmix[4:0] == 5'h1E) ? avg(scl_l_b, scl_r_a)
                                              : avg(scl_l_a, scl_r_b)); // RQ7
            mixed[1] = pick(st.act_volmix[1:0], scl_l_b, scl_r_b,
                (st.act_volmix[4:0] == 5'h13) ? avg(scl_l_b, scl_r_a)
                                              : avg(scl_l_a, scl_r_b)); // RQ7
        end
    end

    // attenuation by level in eighth-dB: shift by whole 6 dB steps approx
    function automatic logic [SAMPLE_W-1:0] atten(input logic [SAMPLE_W-1:0] x,
                                                  input logic [10:0] l);
        logic [5:0] sh;
        logic signed [SAMPLE_W-1:0] sx;
        sh = 6'(l / 11'd48);
        sx = x;
        if (l >= LVL_SILENT) return '0;
        return SAMPLE_W'(sx >>> sh);
    endfunction : atten

    assign scl_l_a = atten(in_l, lvl[0]);
    assign scl_r_a = atten(in_r, lvl[0]);
    assign scl_l_b = atten(in_l, lvl[1]);
    assign scl_r_b = atten(in_r, lvl[1]);

    ////////////////////////////////////////////////////////////////////////////
    // per channel target, crossing detect and level tracker
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            logic [7:0] creg;
            logic [SAMPLE_W-1:0] prev;
            assign creg = (gi == 0 || st.act_volmix[VM_LINK]) ? st.act_cha : st.act_chb; // RQ22
            assign prev = (gi == 0) ? st.prev_a : st.prev_b;
            // mute bit or out-of-range code means full silence
            assign tgt[gi] = (creg[CH_MUTE] || creg[6:0] > MAX_ATTEN) ? LVL_SILENT // RQ8 RQ12
                           : {1'b0, creg[6:0], 3'b000}; // RQ11
            // sign change or zero sample counts as a crossing
            assign zc[gi] = fifo_pop && fifo_valid &&
                            ((mixed[gi] == '0) || (mixed[gi][SAMPLE_W-1] != prev[SAMPLE_W-1])); // RQ3
            vmc_level u_lvl (
                .clk_in      (clk_in),
                .rst_n_in    (rst_n_in),
                .ce_in       (ce_in),
                .frame_in    (frame_pulse && !st.lowpwr),
                .zero_in     (zc[gi]),
                .mode_in     (mode),
                .target_in   (tgt[gi]),
                .level_out   (lvl[gi]),
                .settled_out ()
            );
            // final level and polarity
            always_comb begin
                logic [SAMPLE_W-1:0] v;
                v = st.act_volmix[VM_MIX_H] ? mixed[gi] : atten(mixed[gi], lvl[gi]);
                shaped[gi] = st.act_inv[1-gi] ? SAMPLE_W'(~v + 1'b1) : v; // RQ13
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // register file, freeze shadowing, outputs
    always_comb begin
        logic mute_a, mute_b, frz;
        mute_a  = 1'b0;
        mute_b  = 1'b0;
        frz     = st.mode2[M2_FREEZE];
        next_st = st;
        next_st.frame_d = frame_clock_in;
        // register writes accepted even while frozen
        if (reg_wr_in) begin
            case (reg_addr_in)
                REG_VOLMIX: next_st.volmix = reg_wdata_in;
                REG_CHA:    next_st.cha    = reg_wdata_in;
                REG_CHB:    next_st.chb    = reg_wdata_in;
                REG_MODE2:  next_st.mode2  = {reg_wdata_in[7:1], 1'b0};
                default:    next_st.volmix = st.volmix;
            endcase
        end
        // effects move to the active copy only when not frozen
        if (!frz) begin
            next_st.act_volmix = st.volmix; // RQ17
            next_st.act_cha    = st.cha; // RQ17
            next_st.act_chb    = st.chb; // RQ17
            next_st.act_inv    = st.mode2[M2_INV_A:M2_INV_B]; // RQ17
        end
        // read-back
        case (reg_addr_in)
            REG_VOLMIX: next_st.rdata = st.volmix;
            REG_CHA:    next_st.rdata = st.cha;
            REG_CHB:    next_st.rdata = st.chb;
            REG_MODE2:  next_st.rdata = st.mode2;
            default:    next_st.rdata = 8'h00;
        endcase
        if (!reg_rd_in) next_st.rdata = st.rdata;
        // internal clock enable: divide master clock by two when asked
        if (mclk_in) next_st.mdiv_ph = ~st.mdiv_ph;
        next_st.cken = !st.lowpwr && mclk_in && (!st.mode2[M2_MDIV] || st.mdiv_ph); // RQ18
        next_st.lowpwr = st.mode2[M2_LOWPWR]; // RQ16 RQ20
        next_st.host   = st.mode2[M2_HOST]; // RQ14
        // sample path
        next_st.ovalid = 1'b0;
        if (fifo_pop && fifo_valid) begin
            next_st.ovalid = 1'b1;
            next_st.oa = shaped[0];
            next_st.ob = shaped[1];
            next_st.prev_a = mixed[0];
            next_st.prev_b = mixed[1];
        end
        if (st.lowpwr) begin
            next_st.oa = '0; // RQ16
            next_st.ob = '0;
        end
        // silence flags follow mute bits, out-of-range codes and low power
        mute_a = (tgt[0] == LVL_SILENT) || st.lowpwr; // RQ9 RQ12
        mute_b = (tgt[1] == LVL_SILENT) || st.lowpwr; // RQ9 RQ12 RQ22
        if (st.mode2[M2_FLINK]) begin
            next_st.flag_a = mute_a && mute_b; // RQ10
            next_st.flag_b = mute_a && mute_b; // RQ10
        end else begin
            next_st.flag_a = mute_a; // RQ9
            next_st.flag_b = mute_b; // RQ9
        end
    end

    // reset restores every register to default
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '0; // RQ19
            st.volmix <= RST_VOLMIX; // RQ5 RQ6
            st.act_volmix <= RST_VOLMIX;
            st.cha <= RST_CH; // RQ11
            st.chb <= RST_CH;
            st.act_cha <= RST_CH;
            st.act_chb <= RST_CH;
            st.mode2 <= RST_MODE2; // RQ14 RQ16
            st.lowpwr <= 1'b1; // RQ20
            st.flag_a <= 1'b1;
            st.flag_b <= 1'b1;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    assign reg_rdata_out           = st.rdata;
    assign out_valid_out           = st.ovalid;
    assign out_a_out               = st.oa;
    assign out_b_out               = st.ob;
    assign chan_a_silence_flag_out = st.flag_a;
    assign chan_b_silence_flag_out = st.flag_b;
    assign low_power_out           = st.lowpwr;
    assign host_port_on_out        = st.host;
    assign core_clk_en_out         = st.cken;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_frz_write;
        st.mode2[M2_FREEZE] && reg_wr_in && reg_addr_in == REG_CHA;
    endsequence
    AST_FREEZE_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (s_frz_write and ce_in) |=> (st.act_cha == $past(st.act_cha)))
        else $error("frozen write took effect"); // RQ17
    AST_FLAG_LINK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && st.mode2[M2_FLINK]) |=> (chan_a_silence_flag_out == chan_b_silence_flag_out))
        else $error("linked silence flags differ"); // RQ10
    AST_LOWPWR_OUT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && st.lowpwr) |=> (out_a_out == '0 && out_b_out == '0))
        else $error("output not silent in low power"); // RQ16
    AST_MUTE_FLAG: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && st.act_cha[CH_MUTE] && !st.mode2[M2_FLINK]) |=> chan_a_silence_flag_out)
        else $error("mute flag a not active"); // RQ9
    AST_HOST_BIT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in |=> (host_port_on_out == $past(st.mode2[M2_HOST])))
        else $error("host port state wrong"); // RQ14
    AST_OVER_RANGE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (st.act_cha[6:0] > MAX_ATTEN) |-> (tgt[0] == LVL_SILENT))
        else $error("out of range code not muted"); // RQ12
endmodule : vmc_top

// ---- verification/vmc_src.sv ----
// sample source model feeding the pair fifo and the frame clock
// assumes the bench pulses go_in for one cycle per frame
module vmc_src (
    input  wire logic        clk_in,
    input  wire logic        go_in,
    input  wire logic [23:0] l_in,
    input  wire logic [23:0] r_in,
    input  wire logic        ready_in,
    output logic             valid_out,
    output logic [23:0]      l_out,
    output logic [23:0]      r_out,
    output logic             frame_out,
    output logic             done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 32'h0000_6d6c;
    // random stall, push one pair, then one frame clock period
    initial begin
        {valid_out, frame_out, done_out, l_out, r_out} = '0;
        forever begin
            @(posedge clk_in);
            done_out <= 1'b0;
            if (go_in) begin
                repeat ($unsigned($random(seed)) % 3) @(posedge clk_in);
                valid_out <= 1'b1;
                l_out     <= l_in;
                r_out     <= r_in;
                do @(posedge clk_in); while (ready_in !== 1'b1);
                valid_out <= 1'b0;
                l_out     <= ~l_in;  // released data not held
                r_out     <= ~r_in;
                frame_out <= 1'b1;
                repeat (2) @(posedge clk_in);
                frame_out <= 1'b0;
                repeat (2) @(posedge clk_in);
                done_out  <= 1'b1;
            end
        end
    end
endmodule : vmc_src

// ---- verification/vmc_top_tb.sv ----
// self-checking bench for the volume, mix and mute block
// assumes the sample source model and the design package
module vmc_top_tb;
    import vmc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0, rst_n_in = 1'b0, mclk = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00, rdata;
    logic [4:0]  k;
    logic [23:0] l = 24'h00_0000, r = 24'h00_0000, sl, sr, oa, ob;
    logic        sv, rdy, fr, done, fa, fb, lp, hp, ce_o, ov, vs;
    int          fail_count = 0, compares = 0, seed = 32'h0000_6d6c, n;

    // clocks
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) mclk <= ~mclk;

    vmc_top u_vmc_top (.clk_in, .rst_n_in, .ce_in(1'b1), .mclk_in(mclk), .frame_clock_in(fr),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .smp_valid_in(sv), .smp_ready_out(rdy), .smp_left_in(sl), .smp_right_in(sr), .out_valid_out(ov),
        .out_a_out(oa), .out_b_out(ob), .chan_a_silence_flag_out(fa), .chan_b_silence_flag_out(fb),
        .low_power_out(lp), .host_port_on_out(hp), .core_clk_en_out(ce_o));
    vmc_src u_vmc_src (.clk_in, .go_in(go), .l_in(l), .r_in(r), .ready_in(rdy), .valid_out(sv),
        .l_out(sl), .r_out(sr), .frame_out(fr), .done_out(done));

    ////////////////////////////////////////
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_in);
        wr <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk_in);
        rd <= 1'b0;
        @(negedge clk_in);
        check(24'(rdata), 24'(exp));
    endtask : rd_reg

    // one pair through the fifo, bounded wait on the source
    task automatic frame(input logic [23:0] a, input logic [23:0] b);
        @(posedge clk_in);
        go <= 1'b1;
        l  <= a;
        r  <= b;
        @(posedge clk_in);
        go <= 1'b0;
        vs = 1'b0;
        for (n = 0; n < 40 && done !== 1'b1; n++) begin
            @(posedge clk_in);
            vs = vs | ov;
        end
        #1;
        if (n == 40) begin
            fail_count++;
            $display("unexpected at %0t: source timeout", $time);
            give_verdict();
        end
        check(24'(vs), 24'h1);
    endtask : frame

    task automatic pos(input int cnt);
        repeat (cnt) frame(24'h12_3456, 24'h00_0100);
    endtask : pos

    // expected mixer leg at full level
    function automatic logic [23:0] pick(input logic [1:0] c, input logic [23:0] a, input logic [23:0] b);
        logic [24:0] s;
        s = {a[23], a} + {b[23], b};
        case (c)
            2'b00:   pick = 24'h00_0000;
            2'b01:   pick = b;
            2'b10:   pick = a;
            default: pick = s[24:1];
        endcase
    endfunction : pick

    ////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_in);
        #1;
        check(24'({fa, fb, lp, hp}), 24'he);
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd_reg(REG_VOLMIX, 8'h49);
        rd_reg(REG_CHA, 8'h00);
        rd_reg(REG_CHB, 8'h00);
        rd_reg(REG_MODE2, 8'h10);
        rd_reg(3'h7, 8'h00);
        check(24'(ce_o), 24'h0);
        wr_reg(REG_MODE2, 8'h11);
        rd_reg(REG_MODE2, 8'h10);
        wr_reg(REG_MODE2, 8'h20);
        check(24'({lp, hp, fa}), 24'h2);
        $display("test registers done");
        for (int c = 0; c < 32; c++) begin
            k = 5'(c);
            wr_reg(REG_VOLMIX, {3'b000, k});
            frame(24'($random(seed)), 24'($random(seed)));
            check(oa, pick(k[3:2], l, r));
            check(ob, pick(k[1:0], l, r));
        end
        wr_reg(REG_VOLMIX, 8'h09);
        wr_reg(REG_MODE2, 8'he0);
        frame(24'($random(seed)), 24'($random(seed)));
        check(oa, -l);
        check(ob, -r);
        $display("test mix and invert done");
        wr_reg(REG_MODE2, 8'h20);
        wr_reg(REG_MODE2, 8'h24);
        wr_reg(REG_CHA, 8'h80);
        pos(1);
        check(oa, l);
        check(24'(fa), 24'h0);
        wr_reg(REG_MODE2, 8'h20);
        pos(1);
        check(oa, 24'h00_0000);
        check(24'({fa, fb}), 24'h2);
        wr_reg(REG_MODE2, 8'h28);
        check(24'({fa, fb}), 24'h0);
        wr_reg(REG_CHB, 8'h78);
        pos(1);
        check(24'({fa, fb}), 24'h3);
        check(ob, 24'h00_0000);
        $display("test freeze and mute done");
        wr_reg(REG_CHA, 8'h00);
        wr_reg(REG_MODE2, 8'h20);
        wr_reg(REG_VOLMIX, 8'h49);
        wr_reg(REG_CHA, 8'h80);
        pos(8);
        check(oa, l);
        pos(970);
        check(oa, 24'h00_0000);
        wr_reg(REG_VOLMIX, 8'h09);
        wr_reg(REG_CHA, 8'h00);
        wr_reg(REG_VOLMIX, 8'h29);
        wr_reg(REG_CHA, 8'h80);
        pos(500);
        check(oa, l);
        pos(530);
        check(oa, 24'h00_0000);
        $display("test ramp and crossing done");
        wr_reg(REG_VOLMIX, 8'h89);
        wr_reg(REG_CHA, 8'h00);
        pos(1);
        check(oa, l);
        check(ob, r);
        $display("test volume link done");
        wr_reg(REG_MODE2, 8'h22);
        n = 0;
        repeat (8) begin
            @(posedge clk_in);
            n += int'(ce_o);
        end
        check(24'(n), 24'h2);
        $display("test clock divide done");
        give_verdict();
    end
endmodule : vmc_top_tb
